// File: rtl/tpc_pkg.sv
package tpc_pkg;
  // Timing base
  localparam longint unsigned CLK_HZ = 64'd100_000_000;
  localparam longint unsigned IDLE_MIN = 64'd5;
  localparam logic [35:0] IDLE_CYCLES = 36'(IDLE_MIN * 64'd60 * CLK_HZ);
  localparam longint unsigned OSD_WIN_S = 64'd5;
  localparam logic [31:0] OSD_WIN_CYCLES = 32'(OSD_WIN_S * CLK_HZ);
  localparam longint unsigned CLICK_MS = 64'd10;
  localparam logic [23:0] CLICK_CYCLES = 24'(CLICK_MS * CLK_HZ / 64'd1000);
  localparam longint unsigned BLINK_MS = 64'd500;
  localparam logic [31:0] BLINK_CYCLES = 32'(BLINK_MS * CLK_HZ / 64'd1000);
  // Serial link comes up at 9600 baud, 8 data bits, no parity, 1 stop
  localparam longint unsigned BAUD_BPS = 64'd9600;
  localparam logic [15:0] BAUD_DIV =
    16'((CLK_HZ + BAUD_BPS / 64'd2) / BAUD_BPS);

  // Register port map
  localparam logic [7:0] ADDR_CMD_SER = 8'h00;
  localparam logic [7:0] ADDR_CMD_USB = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [2:0] ADDR_SET_HI = 3'h1;
  localparam int STATUS_W = 11;

  // Host command codes
  localparam logic [7:0] CMD_DISP_ON_A = 8'h65;
  localparam logic [7:0] CMD_DISP_ON_B = 8'h67;
  localparam logic [7:0] CMD_DISP_OFF_A = 8'h66;
  localparam logic [7:0] CMD_DISP_OFF_B = 8'h68;
  localparam logic [7:0] CMD_CLK_HI_ON = 8'h69;
  localparam logic [7:0] CMD_CLK_HI_OFF = 8'h6a;
  localparam logic [7:0] CMD_CLK_LO_ON = 8'h6b;
  localparam logic [7:0] CMD_CLK_LO_OFF = 8'h6c;
  localparam logic [7:0] CMD_BUZ_HI_ON = 8'h71;
  localparam logic [7:0] CMD_BUZ_HI_OFF = 8'h72;
  localparam logic [7:0] CMD_BUZ_LO_ON = 8'h73;
  localparam logic [7:0] CMD_BUZ_LO_OFF = 8'h74;

  // Touch report headers
  localparam logic [7:0] HDR_TOUCH = 8'h11;
  localparam logic [7:0] HDR_RELEASE = 8'h10;
  localparam logic [2:0] RPT_TAIL = 3'h4;

  // Sound source select, highest priority first
  localparam logic [1:0] SND_BUZ_HI = 2'h0;
  localparam logic [1:0] SND_BUZ_LO = 2'h1;
  localparam logic [1:0] SND_CLK_HI = 2'h2;
  localparam logic [1:0] SND_CLK_LO = 2'h3;

  // Menu keys; codes below KEY_NUM_SET pick an adjustment item
  localparam logic [4:0] KEY_NUM_SET = 5'h08;
  localparam logic [4:0] KEY_CLEAR = 5'h08;
  localparam logic [4:0] KEY_PLUS = 5'h09;
  localparam logic [4:0] KEY_MINUS = 5'h0a;
  localparam logic [4:0] KEY_SET = 5'h0b;
  localparam logic [4:0] KEY_ESC = 5'h0c;
  localparam logic [4:0] KEY_START = 5'h0d;
  localparam logic [4:0] KEY_PT1 = 5'h10;
  localparam logic [4:0] KEY_PT2 = 5'h11;
  localparam logic [4:0] KEY_PT3 = 5'h12;
  localparam int NUM_SET = 8;
  localparam logic [7:0] SET_DEFAULT = 8'h80;
  localparam logic [7:0] SET_MAX = 8'hff;
  localparam logic [7:0] SET_MIN = 8'h00;

  typedef enum logic [2:0] {
    OSD_IDLE, OSD_PT2, OSD_PT3, OSD_MAIN, OSD_ADJ, OSD_CLEAR
  } tpc_osd_e;
endpackage : tpc_pkg

// File: rtl/tpc_top.sv
`timescale 1ns/1ps
// Behaviour
// - Auto mode: backlight off after 5 idle minutes
// - Backlight returns on next serial byte or touch
// - Display command cancels auto backlight off
// - Click switch on gives click per touch
// - Switch picks USB or serial for traffic
// - Switches sampled once after power-on only
// - Single-byte commands obeyed only on the port the switch selects
// - Codes 65h, 67h turn display on
// - Codes 66h, 68h turn display off
// - 69h/6Ah enable/disable high click
// - 6Bh/6Ch enable/disable low click
// - 71h/72h switch high buzzer on/off
// - 73h/74h switch low buzzer on/off
// - Indicator colour shows backlight and image state
// - Three points within 5 s open menu
// - Plus/minus step selected value by one
// - Set stores value, escape returns to main
// - Escape in main menu leaves menu
// - Clear screen start restores factory defaults
// - Power-on clears buffer, serial 9600 8N1
// - Report 11h,X,X,Y,Y; single 10h on release
// - One sound at a time by priority
module tpc_top #(
  parameter logic [35:0] IDLE_CYCLES = tpc_pkg::IDLE_CYCLES,
  parameter logic [31:0] OSD_WIN_CYCLES = tpc_pkg::OSD_WIN_CYCLES,
  parameter logic [23:0] CLICK_CYCLES = tpc_pkg::CLICK_CYCLES,
  parameter logic [31:0] BLINK_CYCLES = tpc_pkg::BLINK_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [15:0] reg_rdata_ff,
  // Setup switches
  input wire logic auto_backlight_off_switch,
  input wire logic click_enable_switch,
  input wire logic factory_adjust_switch,
  input wire logic touch_port_select_switch,
  // Touch panel
  input wire logic touch_down,
  input wire logic touch_sample,
  input wire logic [9:0] touch_x,
  input wire logic [9:0] touch_y,
  // Menu keys
  input wire logic osd_key_valid,
  input wire logic [4:0] osd_key,
  // Panel monitors
  input wire logic backlight_fail,
  input wire logic image_present,
  // Touch report stream
  input wire logic tx_ready,
  output logic tx_valid_ff,
  output logic [7:0] tx_data_ff,
  output logic tx_usb_ff,
  // Display
  output logic display_on_ff,
  output logic backlight_on_ff,
  // Sound
  output logic sound_on_ff,
  output logic [1:0] sound_sel_ff,
  // Indicator
  output logic led_green_ff,
  output logic led_red_ff,
  // Menu
  output logic osd_active_ff,
  output logic [2:0] osd_sel_ff,
  output logic [7:0] osd_value_ff,
  // Setup state
  output logic use_usb_ff,
  output logic factory_mode_ff,
  output logic [15:0] baud_div_ff
);
  localparam logic [35:0] IDLE_LAST = IDLE_CYCLES - 36'h1;
  localparam logic [31:0] OSD_LAST = OSD_WIN_CYCLES - 32'h1;
  localparam logic [31:0] BLINK_LAST = BLINK_CYCLES - 32'h1;

  logic sampled_ff;
  logic auto_en_ff;
  logic auto_off_ff;
  logic click_hi_ff;
  logic click_lo_ff;
  logic buz_hi_ff;
  logic buz_lo_ff;
  logic touch_q_ff;
  logic [35:0] idle_cnt_ff;
  logic [23:0] click_cnt_ff;
  logic [31:0] blink_cnt_ff;
  logic blink_ph_ff;
  logic [31:0] rpt_buf_ff;
  logic [2:0] rpt_rem_ff;
  logic samp_pend_ff;
  logic rel_pend_ff;
  logic [9:0] samp_x_ff;
  logic [9:0] samp_y_ff;
  tpc_pkg::tpc_osd_e osd_st_ff;
  tpc_pkg::tpc_osd_e nxt_osd_st;
  logic [31:0] osd_tmr_ff;
  logic [7:0] saved_ff [tpc_pkg::NUM_SET];

  // Command decode; only the selected port is obeyed
  wire ser_wr = reg_we && reg_addr == tpc_pkg::ADDR_CMD_SER;
  wire usb_wr = reg_we && reg_addr == tpc_pkg::ADDR_CMD_USB;
  wire cmd_ok = sampled_ff && (use_usb_ff ? usb_wr : ser_wr);
  wire [7:0] cmd = reg_wdata;
  wire disp_on = cmd_ok && (cmd == tpc_pkg::CMD_DISP_ON_A ||
    cmd == tpc_pkg::CMD_DISP_ON_B);
  wire disp_off = cmd_ok && (cmd == tpc_pkg::CMD_DISP_OFF_A ||
    cmd == tpc_pkg::CMD_DISP_OFF_B);
  wire disp_cmd = disp_on || disp_off;
  wire ckh_on = cmd_ok && cmd == tpc_pkg::CMD_CLK_HI_ON;
  wire ckh_off = cmd_ok && cmd == tpc_pkg::CMD_CLK_HI_OFF;
  wire ckl_on = cmd_ok && cmd == tpc_pkg::CMD_CLK_LO_ON;
  wire ckl_off = cmd_ok && cmd == tpc_pkg::CMD_CLK_LO_OFF;
  wire bzh_on = cmd_ok && cmd == tpc_pkg::CMD_BUZ_HI_ON;
  wire bzh_off = cmd_ok && cmd == tpc_pkg::CMD_BUZ_HI_OFF;
  wire bzl_on = cmd_ok && cmd == tpc_pkg::CMD_BUZ_LO_ON;
  wire bzl_off = cmd_ok && cmd == tpc_pkg::CMD_BUZ_LO_OFF;

  // Setup and command state; other codes fall through unchanged
  wire nxt_auto_en = !sampled_ff ? auto_backlight_off_switch :
    (disp_cmd ? 1'b0 : auto_en_ff);
  wire nxt_disp = disp_on ? 1'b1 : (disp_off ? 1'b0 : display_on_ff);
  wire nxt_ckh = !sampled_ff ? click_enable_switch :
    (ckh_on ? 1'b1 : (ckh_off ? 1'b0 : click_hi_ff));
  wire nxt_ckl = ckl_on ? 1'b1 : (ckl_off ? 1'b0 : click_lo_ff);
  wire nxt_bzh = bzh_on ? 1'b1 : (bzh_off ? 1'b0 : buz_hi_ff);
  wire nxt_bzl = bzl_on ? 1'b1 : (bzl_off ? 1'b0 : buz_lo_ff);

  always_ff @(posedge clk) begin
    if (rst) begin
      sampled_ff <= 1'b0;
      use_usb_ff <= 1'b0;
      factory_mode_ff <= 1'b0;
      baud_div_ff <= tpc_pkg::BAUD_DIV;
    end else if (!sampled_ff) begin
      // Switches are caught once; later moves are ignored
      sampled_ff <= 1'b1;
      use_usb_ff <= touch_port_select_switch;
      factory_mode_ff <= factory_adjust_switch;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      auto_en_ff <= 1'b0;
      display_on_ff <= 1'b1;
      click_hi_ff <= 1'b0;
      click_lo_ff <= 1'b0;
      buz_hi_ff <= 1'b0;
      buz_lo_ff <= 1'b0;
    end else begin
      auto_en_ff <= nxt_auto_en;
      display_on_ff <= nxt_disp;
      click_hi_ff <= nxt_ckh;
      click_lo_ff <= nxt_ckl;
      buz_hi_ff <= nxt_bzh;
      buz_lo_ff <= nxt_bzl;
    end
  end

  // Idle watch; a held touch counts as activity throughout
  wire activity = ser_wr || touch_down;
  wire idle_top = idle_cnt_ff == IDLE_LAST;
  wire idle_hit = auto_en_ff && idle_top && !activity &&
    !disp_cmd;
  wire [35:0] nxt_idle = activity ? 36'h0 :
    (idle_top ? idle_cnt_ff : idle_cnt_ff + 36'h1);
  wire nxt_auto_off = (activity || disp_cmd || !auto_en_ff) ? 1'b0 :
    (idle_hit ? 1'b1 : auto_off_ff);

  always_ff @(posedge clk) begin
    if (rst) begin
      idle_cnt_ff <= 36'h0;
      auto_off_ff <= 1'b0;
      backlight_on_ff <= 1'b1;
    end else begin
      idle_cnt_ff <= nxt_idle;
      auto_off_ff <= nxt_auto_off;
      backlight_on_ff <= nxt_disp && !nxt_auto_off;
    end
  end

  // Click timer and sound arbiter
  wire press = touch_down && !touch_q_ff;
  wire release_ev = !touch_down && touch_q_ff;
  wire click_act = click_cnt_ff != 24'h0;
  wire [23:0] nxt_click = (press && (click_hi_ff || click_lo_ff)) ?
    CLICK_CYCLES : (click_act ? click_cnt_ff - 24'h1 : 24'h0);
  wire [1:0] nxt_snd_sel = buz_hi_ff ? tpc_pkg::SND_BUZ_HI :
    (buz_lo_ff ? tpc_pkg::SND_BUZ_LO :
    ((click_act && click_hi_ff) ? tpc_pkg::SND_CLK_HI :
    tpc_pkg::SND_CLK_LO));
  wire nxt_snd_on = buz_hi_ff || buz_lo_ff ||
    (click_act && (click_hi_ff || click_lo_ff));

  always_ff @(posedge clk) begin
    if (rst) begin
      touch_q_ff <= 1'b0;
      click_cnt_ff <= 24'h0;
      sound_sel_ff <= tpc_pkg::SND_BUZ_HI;
      sound_on_ff <= 1'b0;
    end else begin
      touch_q_ff <= touch_down;
      click_cnt_ff <= nxt_click;
      sound_sel_ff <= nxt_snd_sel;
      sound_on_ff <= nxt_snd_on;
    end
  end

  // Report serialiser; one sample is held while a report drains
  wire tx_fire = tx_valid_ff && tx_ready;
  wire tx_last = tx_fire && rpt_rem_ff == 3'h0;
  wire tx_free = !tx_valid_ff || tx_last;
  wire load_smp = tx_free && samp_pend_ff;
  wire load_rel = tx_free && !samp_pend_ff && rel_pend_ff;
  wire take_smp = touch_sample && touch_down;
  wire [31:0] smp_word = {6'h0, samp_x_ff, 6'h0, samp_y_ff};
  wire [7:0] nxt_tx_data = load_smp ? tpc_pkg::HDR_TOUCH :
    (load_rel ? tpc_pkg::HDR_RELEASE :
    (tx_fire ? rpt_buf_ff[31:24] : tx_data_ff));
  wire [2:0] nxt_rem = load_smp ? tpc_pkg::RPT_TAIL :
    (load_rel ? 3'h0 : (tx_fire ? rpt_rem_ff - 3'h1 : rpt_rem_ff));
  wire [31:0] nxt_buf = load_smp ? smp_word :
    (tx_fire ? {rpt_buf_ff[23:0], 8'h00} : rpt_buf_ff);

  always_ff @(posedge clk) begin
    if (rst) begin
      // Power-on leaves the report buffer empty
      tx_valid_ff <= 1'b0;
      tx_data_ff <= 8'h00;
      rpt_buf_ff <= 32'h0;
      rpt_rem_ff <= 3'h0;
      tx_usb_ff <= 1'b0;
    end else begin
      tx_valid_ff <= load_smp || load_rel || (tx_valid_ff && !tx_last);
      tx_data_ff <= nxt_tx_data;
      rpt_buf_ff <= nxt_buf;
      rpt_rem_ff <= nxt_rem;
      tx_usb_ff <= use_usb_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      samp_pend_ff <= 1'b0;
      rel_pend_ff <= 1'b0;
      samp_x_ff <= 10'h0;
      samp_y_ff <= 10'h0;
    end else begin
      // New events win over the clear of the same cycle
      samp_pend_ff <= take_smp || (samp_pend_ff && !load_smp);
      rel_pend_ff <= release_ev || (rel_pend_ff && !load_rel);
      if (take_smp) begin
        samp_x_ff <= touch_x;
        samp_y_ff <= touch_y;
      end
    end
  end

  // Indicator
  wire blink_top = blink_cnt_ff == BLINK_LAST;
  wire nxt_ph = blink_top ? !blink_ph_ff : blink_ph_ff;
  wire nxt_green = backlight_fail ? nxt_ph : 1'b1;
  wire nxt_red = backlight_fail ? (image_present ? !nxt_ph : nxt_ph) :
    !image_present;

  always_ff @(posedge clk) begin
    if (rst) begin
      blink_cnt_ff <= 32'h0;
      blink_ph_ff <= 1'b0;
      led_green_ff <= 1'b0;
      led_red_ff <= 1'b0;
    end else begin
      blink_cnt_ff <= blink_top ? 32'h0 : blink_cnt_ff + 32'h1;
      blink_ph_ff <= nxt_ph;
      led_green_ff <= nxt_green;
      led_red_ff <= nxt_red;
    end
  end

  // Adjustment menu
  wire k_item = osd_key_valid && osd_key < tpc_pkg::KEY_NUM_SET;
  wire k_esc = osd_key_valid && osd_key == tpc_pkg::KEY_ESC;
  wire k_plus = osd_key_valid && osd_key == tpc_pkg::KEY_PLUS;
  wire k_minus = osd_key_valid && osd_key == tpc_pkg::KEY_MINUS;
  wire k_set = osd_key_valid && osd_key == tpc_pkg::KEY_SET;
  wire k_start = osd_key_valid && osd_key == tpc_pkg::KEY_START;
  wire k_clear = osd_key_valid && osd_key == tpc_pkg::KEY_CLEAR;
  wire osd_to = osd_tmr_ff == OSD_LAST;
  wire arming = osd_st_ff == tpc_pkg::OSD_PT2 ||
    osd_st_ff == tpc_pkg::OSD_PT3;
  wire in_adj = osd_st_ff == tpc_pkg::OSD_ADJ;
  wire in_main = osd_st_ff == tpc_pkg::OSD_MAIN;
  wire do_store = in_adj && k_set;
  wire do_reset = osd_st_ff == tpc_pkg::OSD_CLEAR && k_start;
  wire [7:0] nxt_value = (in_main && k_item) ? saved_ff[osd_key[2:0]] :
    ((in_adj && k_plus && osd_value_ff != tpc_pkg::SET_MAX) ?
    osd_value_ff + 8'h01 :
    ((in_adj && k_minus && osd_value_ff != tpc_pkg::SET_MIN) ?
    osd_value_ff - 8'h01 : osd_value_ff));

  always_comb begin
    nxt_osd_st = osd_st_ff;
    case (osd_st_ff)
      tpc_pkg::OSD_IDLE: begin
        if (osd_key_valid && osd_key == tpc_pkg::KEY_PT1) begin
          nxt_osd_st = tpc_pkg::OSD_PT2;
        end
      end
      tpc_pkg::OSD_PT2: begin
        if (osd_to) begin
          nxt_osd_st = tpc_pkg::OSD_IDLE;
        end else if (osd_key_valid) begin
          nxt_osd_st = (osd_key == tpc_pkg::KEY_PT2) ?
            tpc_pkg::OSD_PT3 : tpc_pkg::OSD_IDLE;
        end
      end
      tpc_pkg::OSD_PT3: begin
        if (osd_to) begin
          nxt_osd_st = tpc_pkg::OSD_IDLE;
        end else if (osd_key_valid) begin
          nxt_osd_st = (osd_key == tpc_pkg::KEY_PT3) ?
            tpc_pkg::OSD_MAIN : tpc_pkg::OSD_IDLE;
        end
      end
      tpc_pkg::OSD_MAIN: begin
        if (k_item) begin
          nxt_osd_st = tpc_pkg::OSD_ADJ;
        end else if (k_clear) begin
          nxt_osd_st = tpc_pkg::OSD_CLEAR;
        end else if (k_esc) begin
          nxt_osd_st = tpc_pkg::OSD_IDLE;
        end
      end
      tpc_pkg::OSD_ADJ, tpc_pkg::OSD_CLEAR: begin
        if (k_esc) begin
          nxt_osd_st = tpc_pkg::OSD_MAIN;
        end
      end
      default: begin
        nxt_osd_st = tpc_pkg::OSD_IDLE;
      end
    endcase
  end

  wire nxt_osd_act = nxt_osd_st == tpc_pkg::OSD_MAIN ||
    nxt_osd_st == tpc_pkg::OSD_ADJ || nxt_osd_st == tpc_pkg::OSD_CLEAR;

  always_ff @(posedge clk) begin
    if (rst) begin
      osd_st_ff <= tpc_pkg::OSD_IDLE;
      osd_tmr_ff <= 32'h0;
      osd_active_ff <= 1'b0;
      osd_sel_ff <= 3'h0;
      osd_value_ff <= tpc_pkg::SET_DEFAULT;
    end else begin
      osd_st_ff <= nxt_osd_st;
      // Window runs from the first point, not from each touch
      osd_tmr_ff <= arming ? osd_tmr_ff + 32'h1 : 32'h0;
      osd_active_ff <= nxt_osd_act;
      osd_sel_ff <= (in_main && k_item) ? osd_key[2:0] : osd_sel_ff;
      osd_value_ff <= nxt_value;
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < tpc_pkg::NUM_SET; i++) begin
      if (rst || do_reset) begin
        saved_ff[i] <= tpc_pkg::SET_DEFAULT;
      end else if (do_store && osd_sel_ff == 3'(i)) begin
        saved_ff[i] <= osd_value_ff;
      end
    end
  end

  // Register reads
  wire [tpc_pkg::STATUS_W-1:0] status = {buz_lo_ff, buz_hi_ff,
    click_lo_ff, click_hi_ff, factory_mode_ff, osd_active_ff,
    use_usb_ff, auto_off_ff, auto_en_ff, backlight_on_ff, display_on_ff};
  wire rd_status = reg_addr == tpc_pkg::ADDR_STATUS;
  wire rd_set = reg_addr[7:5] == tpc_pkg::ADDR_SET_HI &&
    reg_addr[1:0] == 2'h0;
  wire [15:0] rd_mux = rd_status ? {5'h00, status} :
    (rd_set ? {8'h00, saved_ff[reg_addr[4:2]]} : 16'h0000);

  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata_ff <= 16'h0000;
    end else begin
      reg_rdata_ff <= reg_re ? rd_mux : 16'h0000;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_pt3_in_time;
    osd_st_ff == tpc_pkg::OSD_PT3 && !osd_to && osd_key_valid &&
      osd_key == tpc_pkg::KEY_PT3;
  endsequence
  sequence s_menu_open;
    osd_st_ff == tpc_pkg::OSD_MAIN && osd_active_ff;
  endsequence

  disp_on_cmd_a: assert property (
    disp_on |=> display_on_ff && backlight_on_ff)
    else $error("display on command ignored");
  disp_off_cmd_a: assert property (
    disp_off |=> !display_on_ff && !backlight_on_ff)
    else $error("display off command ignored");
  auto_cancel_a: assert property (disp_cmd |=> !auto_en_ff [*3])
    else $error("auto backlight off not cancelled");
  idle_off_a: assert property (
    idle_hit |=> auto_off_ff && !backlight_on_ff)
    else $error("idle timeout did not blank backlight");
  bl_wake_a: assert property (
    auto_off_ff && activity |=> !auto_off_ff &&
    backlight_on_ff == display_on_ff)
    else $error("backlight did not wake on activity");
  switch_hold_a: assert property (
    sampled_ff |=> $stable(use_usb_ff) && $stable(factory_mode_ff))
    else $error("setup switch taken after power-on");
  buzz_prio_a: assert property (
    buz_hi_ff |=> sound_on_ff && sound_sel_ff == tpc_pkg::SND_BUZ_HI)
    else $error("high buzzer lost priority");
  click_touch_a: assert property (
    press && click_hi_ff && !buz_hi_ff && !buz_lo_ff |=> ##1 sound_on_ff &&
    sound_sel_ff == tpc_pkg::SND_CLK_HI)
    else $error("touch gave no click");
  route_port_a: assert property (
    tx_valid_ff && sampled_ff |-> tx_usb_ff == use_usb_ff)
    else $error("report sent on wrong port");
  rpt_hdr_a: assert property (
    load_smp |=> tx_valid_ff && tx_data_ff == tpc_pkg::HDR_TOUCH &&
    rpt_rem_ff == tpc_pkg::RPT_TAIL)
    else $error("touch report header wrong");
  osd_entry_a: assert property (s_pt3_in_time |=> s_menu_open)
    else $error("menu not opened after three points");
  osd_exit_a: assert property (
    in_main && k_esc |=> !osd_active_ff && osd_st_ff == tpc_pkg::OSD_IDLE)
    else $error("escape did not leave menu");
  osd_store_a: assert property (
    do_store |=> saved_ff[osd_sel_ff] == $past(osd_value_ff))
    else $error("set did not store value");
  osd_clear_a: assert property (
    do_reset |=> saved_ff[0] == tpc_pkg::SET_DEFAULT &&
    saved_ff[7] == tpc_pkg::SET_DEFAULT)
    else $error("clear did not restore defaults");
  bad_cmd_a: assert property (
    reg_we && !disp_cmd && !ckh_on && !ckh_off &&
    !ckl_on && !ckl_off && !bzh_on && !bzh_off && !bzl_on && !bzl_off &&
    sampled_ff |=> $stable(display_on_ff) && $stable(buz_hi_ff) &&
    $stable(click_lo_ff))
    else $error("undefined code changed state");
endmodule : tpc_top

// File: verification/tpc_host_model.sv
`timescale 1ns/1ps
module tpc_host_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Byte stream from the panel
  input wire logic tx_valid_ff,
  input wire logic [7:0] tx_data_ff,
  input wire logic slow,
  output logic tx_ready,
  // Bytes taken by the host
  output logic rx_stb,
  output logic [7:0] rx_byte
);
  // A slow host drops ready every other cycle, so each byte must stand
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_ready <= 1'b0;
    end else begin
      tx_ready <= slow ? ~tx_ready : 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    rx_stb <= tx_valid_ff & tx_ready & ~rst;
    rx_byte <= tx_data_ff;
  end
endmodule : tpc_host_model

// File: verification/tb_touch_panel_command_control.sv
`timescale 1ns/1ps
module tb_touch_panel_command_control;
  logic clk = 1'b0, rst = 1'b1, reg_we = 1'b0, reg_re = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  logic auto_backlight_off_switch = 1'b1, click_enable_switch = 1'b1;
  logic factory_adjust_switch = 1'b0;
  logic touch_port_select_switch = 1'b0, touch_down = 1'b0;
  logic touch_sample = 1'b0, osd_key_valid = 1'b0, backlight_fail = 1'b0;
  logic image_present = 1'b1, slow = 1'b0, tx_ready, rx_stb;
  logic [9:0] touch_x = 10'h000, touch_y = 10'h000;
  logic [4:0] osd_key = 5'h00;
  logic [7:0] rx_byte, tx_data_ff, osd_value_ff;
  logic [15:0] reg_rdata_ff, baud_div_ff, s;
  logic tx_valid_ff, tx_usb_ff, display_on_ff, backlight_on_ff, sound_on_ff;
  logic led_green_ff, led_red_ff, osd_active_ff, use_usb_ff, factory_mode_ff;
  logic [1:0] sound_sel_ff;
  logic [2:0] osd_sel_ff;
  logic [7:0] rxq[$];
  int failures = 0, checks = 0, cyc = 0;

  always #5 clk = ~clk;

  // Short counts keep the idle, menu and click timers reachable
  tpc_top #(.IDLE_CYCLES(36'd50), .OSD_WIN_CYCLES(32'd40),
    .CLICK_CYCLES(24'd4), .BLINK_CYCLES(32'd8)) dut_u (
    .clk, .rst, .reg_addr, .reg_wdata, .reg_we, .reg_re, .reg_rdata_ff,
    .auto_backlight_off_switch, .click_enable_switch,
    .factory_adjust_switch, .touch_port_select_switch, .touch_down,
    .touch_sample, .touch_x, .touch_y, .osd_key_valid, .osd_key,
    .backlight_fail, .image_present, .tx_ready, .tx_valid_ff, .tx_data_ff,
    .tx_usb_ff, .display_on_ff, .backlight_on_ff, .sound_on_ff,
    .sound_sel_ff, .led_green_ff, .led_red_ff, .osd_active_ff, .osd_sel_ff,
    .osd_value_ff, .use_usb_ff, .factory_mode_ff, .baud_div_ff);
  tpc_host_model host_u (.clk, .rst, .tx_valid_ff, .tx_data_ff, .slow,
    .tx_ready, .rx_stb, .rx_byte);

  always @(posedge clk) if (rx_stb) rxq.push_back(rx_byte);

  task automatic stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stop_test

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks++;
    if (g !== e) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // One command byte per write; the host never sends more
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk);
    reg_re <= 1'b0;
    #1 d = reg_rdata_ff;
  endtask : rd
  task automatic key(input logic [4:0] k);
    @(posedge clk);
    osd_key <= k;
    osd_key_valid <= 1'b1;
    @(posedge clk);
    osd_key_valid <= 1'b0;
    #1;
  endtask : key

  task automatic t_reset;
    chk(baud_div_ff, 16'd10417);
    chk(osd_value_ff, 8'h80);
    rd(8'h08, s);
    chk(s, 16'h0087);
  endtask : t_reset
  task automatic t_auto;
    tick(70);
    chk(backlight_on_ff, 1'b0);
    @(posedge clk);
    touch_down <= 1'b1;
    @(posedge clk);
    touch_down <= 1'b0;
    tick(2);
    chk(backlight_on_ff, 1'b1);
    wr(8'h00, 8'h65);
    tick(70);
    chk(backlight_on_ff, 1'b1);
  endtask : t_auto
  task automatic t_touch;
    logic [7:0] e[6] = '{8'h11, 8'h00, 8'h17, 8'h01, 8'hf4, 8'h10};
    rxq.delete();
    @(posedge clk);
    slow <= 1'b1;
    touch_x <= 10'h017;
    touch_y <= 10'h1f4;
    touch_down <= 1'b1;
    touch_sample <= 1'b1;
    @(posedge clk);
    touch_sample <= 1'b0;
    tick(2);
    chk(sound_on_ff, 1'b1);
    chk(sound_sel_ff, 2'h2);
    for (int i = 0; i < 80 && rxq.size() < 5; i++) @(posedge clk);
    touch_down <= 1'b0;
    for (int i = 0; i < 80 && rxq.size() < 6; i++) @(posedge clk);
    slow <= 1'b0;
    chk(16'(rxq.size()), 16'd6);
    foreach (e[i]) chk(rxq[i], e[i]);
    chk(tx_usb_ff, 1'b0);
  endtask : t_touch
  task automatic t_cmds;
    logic [7:0] c[12] = '{8'h69, 8'h6a, 8'h6b, 8'h6c, 8'h71, 8'h72,
      8'h73, 8'h74, 8'h66, 8'h67, 8'h68, 8'h65};
    int b[12] = '{7, 7, 8, 8, 9, 9, 10, 10, 0, 0, 0, 0};
    logic v;
    for (int i = 0; i < 12; i++) begin
      v = 1'(i < 8) ^ i[0];
      wr(8'h00, c[i]);
      rd(8'h08, s);
      chk(s[b[i]], v);
      if (b[i] == 0) chk(s[1], v);
    end
    wr(8'h00, 8'h6d);
    wr(8'h04, 8'h71);
    rd(8'h08, s);
    chk(s, 16'h0003);
    rd(8'h0c, s);
    chk(s, 16'h0000);
  endtask : t_cmds
  task automatic t_prio;
    wr(8'h00, 8'h71);
    wr(8'h00, 8'h73);
    wr(8'h00, 8'h69);
    tick(1);
    chk(sound_on_ff, 1'b1);
    chk(sound_sel_ff, 2'h0);
    wr(8'h00, 8'h72);
    tick(1);
    chk(sound_sel_ff, 2'h1);
    wr(8'h00, 8'h74);
    wr(8'h00, 8'h6a);
  endtask : t_prio
  task automatic t_osd;
    key(tpc_pkg::KEY_PT1);
    tick(45);
    key(tpc_pkg::KEY_PT2);
    key(tpc_pkg::KEY_PT3);
    chk(osd_active_ff, 1'b0);
    key(tpc_pkg::KEY_PT1);
    key(tpc_pkg::KEY_PT2);
    key(tpc_pkg::KEY_PT3);
    chk(osd_active_ff, 1'b1);
    key(5'h03);
    chk(osd_sel_ff, 3'h3);
    key(tpc_pkg::KEY_PLUS);
    key(tpc_pkg::KEY_PLUS);
    key(tpc_pkg::KEY_MINUS);
    chk(osd_value_ff, 8'h81);
    key(tpc_pkg::KEY_SET);
    key(tpc_pkg::KEY_ESC);
    rd(8'h2c, s);
    chk(s, 16'h0081);
    chk(osd_active_ff, 1'b1);
    key(tpc_pkg::KEY_CLEAR);
    key(tpc_pkg::KEY_START);
    rd(8'h2c, s);
    chk(s, 16'h0080);
    key(tpc_pkg::KEY_ESC);
    key(tpc_pkg::KEY_ESC);
    chk(osd_active_ff, 1'b0);
  endtask : t_osd
  task automatic t_misc;
    chk({led_green_ff, led_red_ff}, 2'b10);
    @(posedge clk);
    image_present <= 1'b0;
    touch_port_select_switch <= 1'b1;
    tick(2);
    chk({led_green_ff, led_red_ff}, 2'b11);
    chk(use_usb_ff, 1'b0);
    // Failed lamp without image: both colours blink together
    @(posedge clk);
    backlight_fail <= 1'b1;
    tick(2);
    chk(led_green_ff, led_red_ff);
    s[1:0] = ~{led_green_ff, led_red_ff};
    tick(8);
    chk({led_green_ff, led_red_ff}, s[1:0]);
    // Second power-up picks up the moved port switch
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    tick(2);
    chk(use_usb_ff, 1'b1);
    chk(tx_usb_ff, 1'b1);
    wr(8'h04, 8'h73);
    wr(8'h00, 8'h71);
    tick(1);
    chk(sound_sel_ff, 2'h1);
  endtask : t_misc

  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    tick(2);
    t_reset();
    t_auto();
    t_touch();
    t_cmds();
    t_prio();
    t_osd();
    t_misc();
    stop_test();
  end
endmodule : tb_touch_panel_command_control
